//--- verilog/ncopb_pkg.sv
// Purpose: Constants and types for the channel A oscillator preset bank
// Assumes: Byte-wide register port, byte addresses, lowest byte holds bits 7:0
// Notes: Each preset takes two 4-byte slots: tuning word, then phase offset
package ncopb_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int PRESETS = 3;
   localparam int WORD_W = 32;
   localparam int PHASE_W = 16;
   localparam int SLOT_BYTES = 4;
   localparam logic [ADDR_W-1:0] ADDR_TUNING0 = 15'h0220;
   localparam logic [ADDR_W-1:0] ADDR_PHASE0 = 15'h0224;
   localparam logic [ADDR_W-1:0] ADDR_TUNING1 = 15'h0228;
   localparam logic [ADDR_W-1:0] ADDR_PHASE1 = 15'h022C;
   localparam logic [ADDR_W-1:0] ADDR_TUNING2 = 15'h0230;
   localparam logic [ADDR_W-1:0] ADDR_PHASE2 = 15'h0234;
   localparam logic [ADDR_W-1:0] BANK_BYTES = 15'h0018;
   localparam logic [WORD_W-1:0] TUNING_RESET = 32'hC0000000;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] ACC_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
   localparam int PHASE_SHIFT = WORD_W - PHASE_W;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ncopb_req_t;

   typedef struct packed {
      logic [PRESETS-1:0][WORD_W-1:0] tuning;
      logic [PRESETS-1:0][PHASE_W-1:0] phase;
      logic [WORD_W-1:0] acc;
      logic [WORD_W-1:0] phase_out;
      logic [DATA_W-1:0] rdata;
   } ncopb_state_t;
endpackage : ncopb_pkg

//--- verilog/ncopb_bank.sv
// Purpose: Channel A oscillator preset bank with phase accumulator
// Assumes: sample_en marks each sample clock; preset_sel chosen elsewhere
// Notes: Register reads answer one cycle after reg.rd with bits from flops
`timescale 1ns/1ns
`default_nettype none
module ncopb_bank (
   input wire logic clk_sys,
   input wire logic rst,
   input wire ncopb_pkg::ncopb_req_t reg_req,
   output logic [ncopb_pkg::DATA_W-1:0] reg_rdata,
   input wire logic sample_en,
   input wire logic phase_init,
   input wire logic [1:0] preset_sel,
   output logic [ncopb_pkg::WORD_W-1:0] nco_phase
);
   ncopb_pkg::ncopb_state_t st;
   ncopb_pkg::ncopb_state_t next_st;
   logic [ncopb_pkg::ADDR_W-1:0] offset;
   logic in_bank;
   logic [2:0] slot;
   logic [1:0] sel_idx;
   logic [ncopb_pkg::WORD_W-1:0] sel_word;
   logic [ncopb_pkg::WORD_W-1:0] sel_offset;
   logic [ncopb_pkg::PRESETS-1:0] hit_tuning;
   logic [ncopb_pkg::PRESETS-1:0] hit_phase;

   assign offset = reg_req.addr - ncopb_pkg::ADDR_TUNING0;
   assign in_bank = (reg_req.addr >= ncopb_pkg::ADDR_TUNING0) && (offset < ncopb_pkg::BANK_BYTES);
   assign slot = offset[4:2];
   // Code 3 names a preset outside this bank, so it falls back to preset 0
   assign sel_idx = (preset_sel < 2'(ncopb_pkg::PRESETS)) ? preset_sel : 2'h0;
   assign sel_word = st.tuning[sel_idx];
   assign sel_offset = {st.phase[sel_idx], 16'h0000};

   // Phase bytes +2/+3 never hit, so writes there fall away and reads give zero
   for (genvar p = 0; p < ncopb_pkg::PRESETS; p++) begin : g_preset
      assign hit_tuning[p] = in_bank && (slot == 3'(2 * p));
      assign hit_phase[p] = in_bank && (slot == 3'(2 * p + 1)) && !offset[1];
   end

   always_comb begin
      next_st = st;
      for (int p = 0; p < ncopb_pkg::PRESETS; p++) begin
         if (reg_req.wr && hit_tuning[p]) begin
            next_st.tuning[p][8*offset[1:0] +: 8] = reg_req.wdata;
         end
         if (reg_req.wr && hit_phase[p]) begin
            next_st.phase[p][8*offset[0] +: 8] = reg_req.wdata;
         end
      end
      if (reg_req.rd) begin
         next_st.rdata = 8'h00;
         if (in_bank && !slot[0]) begin
            next_st.rdata = st.tuning[slot[2:1]][8*offset[1:0] +: 8];
         end else if (in_bank && !offset[1]) begin
            next_st.rdata = st.phase[slot[2:1]][8*offset[0] +: 8];
         end
      end
      // A new tuning word simply joins the running sum; nothing realigns it
      if (phase_init) begin
         next_st.acc = ncopb_pkg::ACC_RESET;
      end else if (sample_en) begin
         next_st.acc = st.acc + sel_word;
      end
      if (sample_en) begin
         next_st.phase_out = st.acc + sel_offset;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st.tuning <= {ncopb_pkg::PRESETS{ncopb_pkg::TUNING_RESET}};
         st.phase <= {ncopb_pkg::PRESETS{ncopb_pkg::PHASE_RESET}};
         st.acc <= ncopb_pkg::ACC_RESET;
         st.phase_out <= ncopb_pkg::ACC_RESET;
         st.rdata <= ncopb_pkg::RDATA_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign nco_phase = st.phase_out;

   // Oscillator side
   a_acc_advance: assert property (@(posedge clk_sys) disable iff (rst)
      sample_en && !phase_init
      |=> st.acc == $past(st.acc) + $past(sel_word))
      else $error("accumulator did not advance by tuning word");

   a_acc_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !sample_en && !phase_init
      |=> $stable(st.acc))
      else $error("accumulator moved without a sample");

   a_init_clears: assert property (@(posedge clk_sys) disable iff (rst)
      phase_init
      |=> st.acc == ncopb_pkg::ACC_RESET)
      else $error("accumulator not cleared by init");

   a_sel_fallback: assert property (@(posedge clk_sys) disable iff (rst)
      sample_en && !phase_init && preset_sel == 2'h3
      |=> st.acc == $past(st.acc) + $past(st.tuning[0]))
      else $error("unused select code did not fall back to preset 0");

   a_no_realign: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && in_bank && !sample_en && !phase_init
      |=> $stable(st.acc))
      else $error("tuning write disturbed accumulator");

   a_retune_runs: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && in_bank && sample_en && !phase_init
      |=> st.acc == $past(st.acc) + $past(sel_word))
      else $error("running retune did not keep the sum going");

   a_phase_sum: assert property (@(posedge clk_sys) disable iff (rst)
      sample_en
      |=> nco_phase == $past(st.acc) + {$past(st.phase[sel_idx]), 16'h0000})
      else $error("phase output not accumulator plus offset");

   a_phase_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !sample_en
      |=> $stable(nco_phase))
      else $error("phase output moved without a sample");

   a_phase_low_kept: assert property (@(posedge clk_sys) disable iff (rst)
      sample_en
      |=> nco_phase[15:0] == $past(st.acc[15:0]))
      else $error("phase offset touched lower half");

   a_phase_turns: assert property (@(posedge clk_sys) disable iff (rst)
      sample_en
      |=> nco_phase[31:16] == 16'($past(st.acc[31:16]) + $past(st.phase[sel_idx])))
      else $error("phase offset did not wrap modulo one turn");

   // Register side
   a_reset_values: assert property (@(posedge clk_sys) disable iff (rst)
      $past(rst)
      |-> st.tuning[1] == 32'hC0000000 && st.phase[2] == 16'h0000 && reg_rdata == 8'h00)
      else $error("reset values wrong");

   a_tuning_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && reg_req.addr == 15'h0233
      |=> st.tuning[2][31:24] == $past(reg_req.wdata))
      else $error("tuning byte write lost");

   a_tuning_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !reg_req.wr
      |=> $stable(st.tuning))
      else $error("tuning word changed without a write");

   a_phase_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && reg_req.addr == 15'h0225
      |=> st.phase[0][15:8] == $past(reg_req.wdata))
      else $error("phase byte write lost");

   a_phase_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.rd && reg_req.addr == 15'h022E
      |=> reg_rdata == 8'h00)
      else $error("unused phase byte not zero");

   a_refused_byte: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && reg_req.addr == 15'h0226
      |=> $stable(st.phase))
      else $error("write to unused phase byte landed");

   a_phase_reg_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !reg_req.wr
      |=> $stable(st.phase))
      else $error("phase register changed without a write");

   a_map_decode: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.rd && reg_req.addr == 15'h022C
      |=> reg_rdata == $past(st.phase[1][7:0]))
      else $error("phase preset 1 decode wrong");

   a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.rd && reg_req.addr == 15'h0238
      |=> reg_rdata == 8'h00)
      else $error("unmapped address read nonzero");

   a_map_tuning2: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.rd && reg_req.addr == 15'h0230
      |=> reg_rdata == $past(st.tuning[2][7:0]))
      else $error("tuning preset 2 decode wrong");

   a_phase0_read: assert property (@(posedge clk_sys) disable iff (rst)
      reg_req.rd && reg_req.addr == 15'h0225
      |=> reg_rdata == $past(st.phase[0][15:8]))
      else $error("phase preset 0 upper byte decode wrong");

   a_rdata_stands: assert property (@(posedge clk_sys) disable iff (rst)
      !reg_req.rd
      |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   // Main scenarios for coverage
   c_tuning_write: cover property (@(posedge clk_sys) disable iff (rst)
      reg_req.wr && reg_req.addr == 15'h0228);

   c_running_retune: cover property (@(posedge clk_sys) disable iff (rst)
      sample_en ##1 reg_req.wr && in_bank && !slot[0] ##1 sample_en);

   c_acc_wrap: cover property (@(posedge clk_sys) disable iff (rst)
      sample_en && !phase_init && (st.acc > st.acc + sel_word));

   c_init_then_run: cover property (@(posedge clk_sys) disable iff (rst)
      phase_init ##1 sample_en [*3]);

   c_sel_fallback: cover property (@(posedge clk_sys) disable iff (rst)
      sample_en && !phase_init && preset_sel == 2'h3);
endmodule : ncopb_bank
`default_nettype wire

//--- tb/ncopb_bank_tb.sv
// Purpose: Self-checking bench for the channel A oscillator preset bank
// Assumes: Byte register port; inputs change on the falling clock edge
// Notes: Phase bytes +2/+3 are written too, so that dropping them is seen
`timescale 1ns/1ns
`default_nettype none
module ncopb_bank_tb;
   logic clk_sys, rst, sample_en, phase_init;
   logic [1:0] preset_sel;
   ncopb_pkg::ncopb_req_t req;
   logic [ncopb_pkg::DATA_W-1:0] reg_rdata;
   logic [ncopb_pkg::WORD_W-1:0] nco_phase, w, t1;
   int miscompares = 0;
   int cmp_count = 0;
   ncopb_bank i_ncopb_bank (.clk_sys(clk_sys), .rst(rst), .reg_req(req),
      .reg_rdata(reg_rdata), .sample_en(sample_en), .phase_init(phase_init),
      .preset_sel(preset_sel), .nco_phase(nco_phase));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   // One byte per rising edge; the strobe stays up over the burst, then rests one edge
   task automatic wrw(input logic [14:0] a, input int n, input logic [31:0] d);
      req.wr = 1'b1;
      for (int i = 0; i < n; i++) begin
         req.addr = a + 15'(i);
         req.wdata = d[8*i+:8];
         @(negedge clk_sys);
      end
      req.wr = 1'b0;
      @(negedge clk_sys);
   endtask : wrw
   task automatic rdw(input logic [14:0] a, input int n, output logic [31:0] d);
      d = 32'h00000000;
      req.rd = 1'b1;
      for (int i = 0; i < n; i++) begin
         req.addr = a + 15'(i);
         @(negedge clk_sys);
         d[8*i+:8] = reg_rdata;
      end
      req.rd = 1'b0;
      @(negedge clk_sys);
   endtask : rdw
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      req = '0;
      sample_en = 1'b0;
      phase_init = 1'b0;
      preset_sel = 2'h0;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      for (int i = 0; i < 3; i++) begin
         rdw(15'h0220 + 15'(8*i), 4, w);
         chk("tuning reset", w, 32'hC0000000);
         rdw(15'h0224 + 15'(8*i), 2, w);
         chk("phase reset", w, 32'h00000000);
         wrw(15'h0220 + 15'(8*i), 4, 32'h92345670 + 32'(i));
         wrw(15'h0224 + 15'(8*i), 4, 32'hFFFFA5C0 + 32'(i));
      end
      for (int i = 0; i < 3; i++) begin
         rdw(15'h0220 + 15'(8*i), 4, w);
         chk("tuning word", w, 32'h92345670 + 32'(i));
         rdw(15'h0224 + 15'(8*i), 4, w);
         chk("phase word", w, 32'h0000A5C0 + 32'(i));
      end
      rdw(15'h0238, 4, w);
      chk("unmapped read", w, 32'h00000000);
      // Clear the accumulator, then three samples on preset 1 (sum wraps)
      t1 = 32'h92345671;
      preset_sel = 2'h1;
      phase_init = 1'b1;
      @(negedge clk_sys);
      phase_init = 1'b0;
      sample_en = 1'b1;
      repeat (3) @(negedge clk_sys);
      sample_en = 1'b0;
      chk("phase out", nco_phase, 32'(2 * t1) + 32'hA5C10000);
      repeat (2) @(negedge clk_sys);
      chk("phase hold", nco_phase, 32'(2 * t1) + 32'hA5C10000);
      // Quarter-rate word on preset 0; code 3 selects it, init and sample collide
      wrw(15'h0220, 4, 32'((64'h1 << 32) / 64'h4));
      preset_sel = 2'h3;
      phase_init = 1'b1;
      sample_en = 1'b1;
      @(negedge clk_sys);
      phase_init = 1'b0;
      chk("init priority", nco_phase, 32'(3 * t1) + 32'hA5C00000);
      repeat (2) @(negedge clk_sys);
      chk("preset 0 run", nco_phase, 32'hE5C00000);
      // Top byte retuned while running: the sum carries on from where it was
      wrw(15'h0223, 1, 32'h00000010);
      chk("running retune", nco_phase, 32'h65C00000);
      @(negedge clk_sys);
      sample_en = 1'b0;
      chk("retune step", nco_phase, 32'h75C00000);
      phase_init = 1'b1;
      @(negedge clk_sys);
      phase_init = 1'b0;
      sample_en = 1'b1;
      @(negedge clk_sys);
      sample_en = 1'b0;
      chk("resync", nco_phase, 32'hA5C00000);
      wrw(15'h0230, 4, (32'h02000000 * 32'h3 + 32'h3) / 32'h7);
      rdw(15'h0230, 4, w);
      chk("rounded word", w, 32'h00DB6DB7);
      // Second reset in mid-run brings every register back
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      chk("rdata after reset", reg_rdata, 32'h00000000);
      chk("phase after reset", nco_phase, 32'h00000000);
      rdw(15'h0230, 4, w);
      chk("tuning re-reset", w, 32'hC0000000);
      repeat (2) @(negedge clk_sys);
      chk("rdata stands", reg_rdata, 32'h000000C0);
      rdw(15'h022C, 2, w);
      chk("phase re-reset", w, 32'h00000000);
      print_verdict();
   end
endmodule : ncopb_bank_tb
`default_nettype wire
